// File: core/twt_pkg.sv
// constants, register map and types of the two-wire target receiver/transmitter
package twt_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses on the apb)
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFF_STAT = 8'h04;
	localparam logic [APB_AW-1:0] OFF_ADDR = 8'h08;
	localparam logic [APB_AW-1:0] OFF_DATA = 8'h0C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK = 6;
	localparam int CTL_STA = 5;
	localparam int CTL_STO = 4;
	localparam int CTL_EN = 2;
	localparam int ADR_GC = 0;

	// ----------------------------------------------------------------
	// reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] SC_SR_OWN = 8'h60;
	localparam logic [7:0] SC_SR_OWN_ARB = 8'h68;
	localparam logic [7:0] SC_SR_GC = 8'h70;
	localparam logic [7:0] SC_SR_GC_ARB = 8'h78;
	localparam logic [7:0] SC_SR_DATA_ACK = 8'h80;
	localparam logic [7:0] SC_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] SC_SR_GC_ACK = 8'h90;
	localparam logic [7:0] SC_SR_GC_NACK = 8'h98;
	localparam logic [7:0] SC_ST_OWN = 8'hA8;
	localparam logic [7:0] SC_ST_OWN_ARB = 8'hB0;
	localparam logic [7:0] SC_ST_DATA_ACK = 8'hB8;
	localparam logic [7:0] SC_ST_DATA_NACK = 8'hC0;
	localparam logic [7:0] SC_ST_LAST_ACK = 8'hC8;
	localparam logic [7:0] SC_IDLE = 8'hF8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_AACK = 8'h04,
		ST_HOLD = 8'h08,
		ST_RXD = 8'h10,
		ST_RACK = 8'h20,
		ST_TXD = 8'h40,
		ST_TACK = 8'h80
	} twt_state_t;

	typedef enum logic [1:0] {
		NX_RX = 2'h0,
		NX_TX = 2'h1,
		NX_END = 2'h2
	} twt_next_t;
endpackage

// File: core/twt_sync.sv
// two flip-flop synchroniser for the bus lines
`timescale 1ns/1ns
`default_nettype none
module twt_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// lines
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} twt_sync_t;

	twt_sync_t r;
	twt_sync_t next_r;

	always_comb begin
		next_r.s1 = i_async;
		next_r.s2 = r.s1;
	end

	// idle bus lines are high, so reset to ones
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign o_sync = r.s2;
endmodule
`default_nettype wire

// File: core/twt_cond.sv
// scl edge and start/stop condition detector on synchronised lines
`timescale 1ns/1ns
`default_nettype none
module twt_cond (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// synchronised lines
	input wire logic i_scl,
	input wire logic i_sda,
	// events
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);
	typedef struct packed {
		logic scl;
		logic sda;
	} twt_cond_t;

	twt_cond_t r;
	twt_cond_t next_r;

	always_comb begin
		next_r.scl = i_scl;
		next_r.sda = i_sda;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign o_scl_rise = i_scl && !r.scl;
	assign o_scl_fall = !i_scl && r.scl;
	// sda moving while scl stays high marks a condition
	assign o_start = i_scl && r.scl && r.sda && !i_sda;
	assign o_stop = i_scl && r.scl && !r.sda && i_sda;
endmodule
`default_nettype wire

// File: core/twt_target.sv
// two-wire target receiver/transmitter with apb registers
`timescale 1ns/1ns
`default_nettype none
module twt_target
	import twt_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [twt_pkg::APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// two-wire bus, open drain
	input wire logic i_scl,
	output logic o_scl_out,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// system side
	input wire logic i_arb_lost,
	input wire logic i_sleep,
	output logic o_wake,
	output logic o_start_go
);
	import twt_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		twt_state_t st;
		twt_next_t nxt;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic gc;
		logic arb;
		logic plan_ack;
		logic tx_last;
		logic phase;
		logic busy;
		logic start_pend;
		logic start_go;
		logic wake;
		logic flag;
		logic ack_en;
		logic sta;
		logic sto;
		logic en;
		logic [7:0] code;
		logic [7:0] own;
		logic [7:0] data;
		logic [31:0] prdata;
	} twt_regs_t;

	twt_regs_t r;
	twt_regs_t next_r;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic cond_start;
	logic cond_stop;
	logic wr;
	logic clear_req;
	logic set_flag;
	logic own_hit;
	logic gc_hit;
	logic [7:0] addr_byte;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
		return a == off;
	endfunction

	function automatic logic [31:0] read_word(input twt_regs_t s, input logic [APB_AW-1:0] a);
		logic [7:0] b;
		b = RST_BYTE;
		if (reg_hit(a, OFF_CTRL)) begin
			b[CTL_FLAG] = s.flag;
			b[CTL_ACK] = s.ack_en;
			b[CTL_STA] = s.sta;
			b[CTL_STO] = s.sto;
			b[CTL_EN] = s.en;
		end else if (reg_hit(a, OFF_STAT)) begin
			b = s.code;
		end else if (reg_hit(a, OFF_ADDR)) begin
			b = s.own;
		end else if (reg_hit(a, OFF_DATA)) begin
			b = s.data;
		end
		return {24'h000000, b};
	endfunction

	// ----------------------------------------------------------------
	// bus line conditioning
	// ----------------------------------------------------------------
	twt_sync #(
		.W(2)
	) u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_async({i_scl, i_sda}),
		.o_sync({scl_s, sda_s})
	);

	twt_cond u_cond (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_scl(scl_s),
		.i_sda(sda_s),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(cond_start),
		.o_stop(cond_stop)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.start_go = 1'b0;
		next_r.wake = 1'b0;
		set_flag = 1'b0;
		clear_req = 1'b0;
		wr = i_psel && i_penable && i_pwrite;
		addr_byte = {r.shreg[6:0], sda_s};
		// address match needs ack enable; lsb of own address gates general call
		own_hit = r.ack_en && (addr_byte[7:1] == r.own[7:1]);
		gc_hit = r.ack_en && r.own[ADR_GC] && (addr_byte == GC_ADDR);

		// register access
		if (i_psel && !i_penable) begin
			next_r.prdata = read_word(r, i_paddr);
		end
		if (wr && reg_hit(i_paddr, OFF_CTRL)) begin
			next_r.ack_en = i_pwdata[CTL_ACK];
			next_r.sta = i_pwdata[CTL_STA];
			next_r.sto = i_pwdata[CTL_STO];
			next_r.en = i_pwdata[CTL_EN];
			clear_req = i_pwdata[CTL_FLAG];
		end
		if (wr && reg_hit(i_paddr, OFF_ADDR)) begin
			next_r.own = i_pwdata[7:0];
		end
		if (wr && reg_hit(i_paddr, OFF_DATA)) begin
			next_r.data = i_pwdata[7:0];
		end

		// bus occupancy, seen even when not addressed
		if (cond_start) begin
			next_r.busy = 1'b1;
		end
		if (cond_stop) begin
			next_r.busy = 1'b0;
		end

		if (!r.en) begin
			next_r.st = ST_IDLE;
		end else if (cond_start && r.st != ST_HOLD) begin
			next_r.st = ST_ADDR;
			next_r.cnt = 4'h0;
		end else if (cond_stop && r.st != ST_HOLD) begin
			next_r.st = ST_IDLE;
		end else begin
			case (r.st)
				ST_IDLE: begin
				end
				ST_ADDR: begin
					if (scl_rise) begin
						next_r.shreg = addr_byte;
						next_r.cnt = r.cnt + 4'h1;
						if (r.cnt == BITS_PER_BYTE - 4'h1) begin
							if (own_hit || gc_hit) begin
								next_r.st = ST_AACK;
								next_r.phase = 1'b0;
								next_r.gc = gc_hit && !own_hit;
								next_r.arb = i_arb_lost;
								next_r.nxt = addr_byte[0] ? NX_TX : NX_RX;
								next_r.wake = i_sleep;
							end else begin
								next_r.st = ST_IDLE;
							end
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (!r.phase) begin
							next_r.phase = 1'b1;
						end else begin
							set_flag = 1'b1;
							next_r.st = ST_HOLD;
							if (r.nxt == NX_TX) begin
								next_r.code = r.arb ? SC_ST_OWN_ARB : SC_ST_OWN;
							end else if (r.gc) begin
								next_r.code = r.arb ? SC_SR_GC_ARB : SC_SR_GC;
							end else begin
								next_r.code = r.arb ? SC_SR_OWN_ARB : SC_SR_OWN;
							end
						end
					end
				end
				ST_HOLD: begin
					if (r.flag && clear_req) begin
						next_r.cnt = 4'h0;
						next_r.phase = 1'b0;
						next_r.code = SC_IDLE;
						next_r.sto = 1'b0;
						case (r.nxt)
							NX_RX: begin
								next_r.st = ST_RXD;
								next_r.plan_ack = next_r.ack_en;
							end
							NX_TX: begin
								next_r.st = ST_TXD;
								next_r.shreg = next_r.data;
								next_r.tx_last = !next_r.ack_en;
							end
							default: begin
								// unaddressed; recognition follows ack enable
								next_r.st = ST_IDLE;
								next_r.start_pend = next_r.sta;
							end
						endcase
					end
				end
				ST_RXD: begin
					if (scl_rise) begin
						next_r.shreg = addr_byte;
						next_r.cnt = r.cnt + 4'h1;
						if (r.cnt == BITS_PER_BYTE - 4'h1) begin
							next_r.st = ST_RACK;
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						if (!r.phase) begin
							next_r.phase = 1'b1;
						end else begin
							set_flag = 1'b1;
							next_r.st = ST_HOLD;
							// in sleep the byte is not kept
							if (!i_sleep) begin
								next_r.data = r.shreg;
							end
							next_r.nxt = r.plan_ack ? NX_RX : NX_END;
							if (r.gc) begin
								next_r.code = r.plan_ack ? SC_SR_GC_ACK : SC_SR_GC_NACK;
							end else begin
								next_r.code = r.plan_ack ? SC_SR_DATA_ACK : SC_SR_DATA_NACK;
							end
						end
					end
				end
				ST_TXD: begin
					if (scl_rise) begin
						next_r.cnt = r.cnt + 4'h1;
					end
					if (scl_fall) begin
						if (r.cnt == BITS_PER_BYTE) begin
							next_r.st = ST_TACK;
						end else begin
							next_r.shreg = {r.shreg[6:0], 1'b1};
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						next_r.phase = 1'b1;
						next_r.plan_ack = !sda_s;
					end else if (scl_fall && r.phase) begin
						set_flag = 1'b1;
						next_r.st = ST_HOLD;
						next_r.nxt = (!r.plan_ack || r.tx_last) ? NX_END : NX_TX;
						if (!r.plan_ack) begin
							next_r.code = SC_ST_DATA_NACK;
						end else if (r.tx_last) begin
							next_r.code = SC_ST_LAST_ACK;
						end else begin
							next_r.code = SC_ST_DATA_ACK;
						end
					end
				end
				default: begin
					next_r.st = ST_IDLE;
				end
			endcase
		end

		// start handed to the controller side once the bus is free
		if (r.start_pend && !r.busy && r.en) begin
			next_r.start_go = 1'b1;
			next_r.start_pend = 1'b0;
		end

		// a hardware set wins over a software clear
		if (set_flag) begin
			next_r.flag = 1'b1;
		end else if (clear_req) begin
			next_r.flag = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r.st <= ST_IDLE;
			r.nxt <= NX_END;
			r.cnt <= 4'h0;
			r.shreg <= RST_BYTE;
			r.gc <= 1'b0;
			r.arb <= 1'b0;
			r.plan_ack <= 1'b0;
			r.tx_last <= 1'b0;
			r.phase <= 1'b0;
			r.busy <= 1'b0;
			r.start_pend <= 1'b0;
			r.start_go <= 1'b0;
			r.wake <= 1'b0;
			r.flag <= 1'b0;
			r.ack_en <= 1'b0;
			r.sta <= 1'b0;
			r.sto <= 1'b0;
			r.en <= 1'b0;
			r.code <= SC_IDLE;
			r.own <= RST_BYTE;
			r.data <= RST_BYTE;
			r.prdata <= 32'h00000000;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_prdata = r.prdata;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !(reg_hit(i_paddr, OFF_CTRL) ||
		reg_hit(i_paddr, OFF_STAT) || reg_hit(i_paddr, OFF_ADDR) ||
		reg_hit(i_paddr, OFF_DATA));
	assign o_wake = r.wake;
	assign o_start_go = r.start_go;
	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	// stretch scl while software owns the flag, including after a wake
	assign o_scl_oe = (r.st == ST_HOLD) && r.flag;
	assign o_sda_oe = ((r.st == ST_AACK) && r.phase) ||
		((r.st == ST_RACK) && r.phase && r.plan_ack) ||
		((r.st == ST_TXD) && !r.shreg[7]);
endmodule
`default_nettype wire

// File: verification/twt_target_monitor.sv
// assertions on the ports of the two-wire target
`timescale 1ns/1ns
`default_nettype none
module twt_target_monitor
	import twt_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [twt_pkg::APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	// bus and system
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_scl_out,
	input wire logic o_scl_oe,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic i_sleep,
	input wire logic o_wake,
	input wire logic o_start_go
);
	logic clr;
	assign clr = i_psel && i_penable && i_pwrite && i_paddr == OFF_CTRL && i_pwdata[CTL_FLAG];
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	// ----------------
	// sequences
	// ----------------
	sequence s_clear;
		clr;
	endsequence
	sequence s_stat_read;
		i_psel && i_penable && !i_pwrite && i_paddr == OFF_STAT;
	endsequence
	// ----------------
	// properties
	// ----------------
	property p_release;
		s_clear |=> !o_scl_oe;
	endproperty
	a_release: assert property (p_release) else $error("scl held after clear");
	property p_hold;
		$fell(o_scl_oe) |-> $past(clr);
	endproperty
	a_hold: assert property (p_hold) else $error("scl freed without clear");
	property p_stretch_low;
		$rose(o_scl_oe) |-> !i_scl;
	endproperty
	a_stretch_low: assert property (p_stretch_low) else $error("stretch began high");
	property p_sda_phase;
		$changed(o_sda_oe) |-> !$past(i_scl);
	endproperty
	a_sda_phase: assert property (p_sda_phase) else $error("sda moved with scl high");
	property p_wake;
		o_wake |-> $past(i_sleep) ##1 !o_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake pulse");
	property p_wake_hold;
		o_wake |-> ##[1:100] o_scl_oe;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("no hold after wake");
	property p_start_go;
		o_start_go |-> i_scl && i_sda ##1 !o_start_go;
	endproperty
	a_start_go: assert property (p_start_go) else $error("start on busy bus");
	property p_stat;
		s_stat_read |-> o_prdata[2:0] == 3'h0 && o_prdata[31:8] == 24'h0;
	endproperty
	a_stat: assert property (p_stat) else $error("status low bits set");
	property p_open_drain;
		!o_sda_out && !o_scl_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
endmodule
bind twt_target twt_target_monitor u_mon (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .o_prdata, .i_scl, .i_sda, .o_scl_out, .o_scl_oe, .o_sda_out,
	.o_sda_oe, .i_sleep, .o_wake, .o_start_go);
`default_nettype wire

// File: verification/twt_ctl_model.sv
// behavioural two-wire bus controller facing the target
`timescale 1ns/1ns
`default_nettype none
module twt_ctl_model (
	// resolved lines
	input wire logic i_scl,
	input wire logic i_sda,
	// open-drain pulls, high drives the line low
	output var logic o_scl_low,
	output var logic o_sda_low
);
	initial begin
		o_scl_low = 1'h0;
		o_sda_low = 1'h0;
	end
	// releases scl and waits out stretching by the target
	task automatic rise;
		o_scl_low = 1'h0;
		// no limit here: a target that never frees scl runs into the bench watchdog
		while (i_scl !== 1'h1) #8;
		#40;
	endtask
	task automatic start_c;
		#3;
		o_sda_low = 1'h1;
		#40;
		o_scl_low = 1'h1;
		#40;
	endtask
	task automatic stop_c;
		// step off the clock edge on which the caller returned
		#3;
		o_sda_low = 1'h1;
		#40;
		rise();
		o_sda_low = 1'h0;
		#40;
	endtask
	// data changes only while scl is low
	task automatic xbit(input logic b, output logic r);
		o_sda_low = !b;
		#40;
		rise();
		r = i_sda;
		#40;
		o_scl_low = 1'h1;
		#40;
	endtask
	// msb first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic a);
		#3;
		for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
		xbit(ab, a);
	endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the two-wire target receiver/transmitter
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import twt_pkg::*;
	logic i_clk = 1'h0;
	logic i_arst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic arb = 1'h0;
	logic sleep = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake, start_go, m_scl, m_sda, ack;
	logic err;
	wire logic scl = !(m_scl | (scl_oe & !scl_out));
	wire logic sda = !(m_sda | (sda_oe & !sda_out));
	int failures = 0;
	int checks = 0;
	int wakes = 0;
	int gos = 0;
	logic [7:0] rnd = 8'h4B;
	logic [7:0] got, d;
	logic [6:0] own;
	twt_target DUT (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl_out(scl_out),
		.o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_arb_lost(arb), .i_sleep(sleep), .o_wake(wake), .o_start_go(start_go)
	);
	twt_ctl_model m (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		wakes += (wake === 1'h1);
		gos += (start_go === 1'h1);
	end
	// ----------------
	// helpers
	// ----------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] addr_code(input logic g, input logic a);
		return g ? (a ? SC_SR_GC_ARB : SC_SR_GC) : (a ? SC_SR_OWN_ARB : SC_SR_OWN);
	endfunction
	task automatic chk_v(input logic [31:0] got_v, input logic [31:0] exp_v);
		checks++;
		if (got_v !== exp_v) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, got_v, exp_v);
		end
	endtask
	task automatic chk_b(input logic got_b, input logic exp_b);
		checks++;
		if (got_b !== exp_b) begin
			failures++;
			$display("[FAIL] %0t bus bit %b expected %b", $time, got_b, exp_b);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [31:0] x);
		@(posedge i_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge i_clk);
		penable <= 1'h1;
		@(posedge i_clk);
		while (pready !== 1'h1) @(posedge i_clk);
		x = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] x;
		apb(1'h1, a, v, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		apb(1'h0, a, 8'h00, x);
	endtask
	// polls the flag, then reads the masked status code
	task automatic expect_code(input logic [7:0] c);
		logic [31:0] x = 32'h0;
		for (int k = 0; k < 40 && x[CTL_FLAG] !== 1'h1; k++) rd(OFF_CTRL, x);
		chk_b(x[CTL_FLAG], 1'h1);
		rd(OFF_STAT, x);
		chk_v(x & 32'hF8, {24'h0, c});
	endtask
	task automatic nack_end(input logic [7:0] c);
		m.start_c();
		m.xfer({own, 1'h0}, 1'h1, got, ack);
		expect_code(SC_SR_OWN);
		wr(OFF_CTRL, 8'h84);
		m.xfer(8'h5A, 1'h1, got, ack);
		chk_b(ack, 1'h1);
		expect_code(SC_SR_DATA_NACK);
		wr(OFF_CTRL, c);
		m.stop_c();
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		final_report();
	end
	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'h1;
		rd(OFF_STAT, r);
		chk_v(r, {24'h0, SC_IDLE});
		rd(OFF_ADDR, r);
		chk_v(r, 32'h0);
		chk_b(err, 1'h0);
		rd(8'h10, r);
		chk_v(r, 32'h0);
		chk_b(err, 1'h1);
		rnd = lfsr(rnd);
		own = rnd[6:0] | 7'h10;
		wr(OFF_ADDR, {own, 1'h1});
		wr(OFF_CTRL, 8'h44);
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk);
			arb <= i[0];
			m.start_c();
			m.xfer(i[1] ? GC_ADDR : {own, 1'h0}, 1'h1, got, ack);
			chk_b(ack, 1'h0);
			@(posedge i_clk);
			arb <= 1'h0;
			expect_code(addr_code(i[1], i[0]));
			wr(OFF_CTRL, 8'hC4);
			rnd = lfsr(rnd);
			d = rnd;
			m.xfer(d, 1'h1, got, ack);
			chk_b(ack, 1'h0);
			expect_code(i[1] ? SC_SR_GC_ACK : SC_SR_DATA_ACK);
			rd(OFF_DATA, r);
			chk_v(r, {24'h0, d});
			wr(OFF_CTRL, 8'h84);
			m.xfer(~d, 1'h1, got, ack);
			chk_b(ack, 1'h1);
			expect_code(i[1] ? SC_SR_GC_NACK : SC_SR_DATA_NACK);
			wr(OFF_CTRL, 8'hC4);
			m.stop_c();
		end
		nack_end(8'h84);
		wr(OFF_ADDR, {own, 1'h0});
		for (int i = 0; i < 3; i++) begin
			m.start_c();
			m.xfer(i == 1 ? GC_ADDR : {own ^ {6'h0, i[1]}, 1'h0}, 1'h1, got, ack);
			chk_b(ack, 1'h1);
			m.stop_c();
			wr(OFF_CTRL, 8'h44);
		end
		wr(OFF_ADDR, {own, 1'h1});
		nack_end(8'hE4);
		repeat (30) @(posedge i_clk);
		chk_v(gos, 1);
		wr(OFF_CTRL, 8'h44);
		m.start_c();
		m.xfer({own, 1'h1}, 1'h1, got, ack);
		expect_code(SC_ST_OWN);
		rnd = lfsr(rnd);
		wr(OFF_DATA, rnd);
		wr(OFF_CTRL, 8'h84);
		m.xfer(8'hFF, 1'h0, got, ack);
		chk_v({24'h0, got}, {24'h0, rnd});
		expect_code(SC_ST_LAST_ACK);
		wr(OFF_CTRL, 8'hC4);
		m.stop_c();
		@(posedge i_clk);
		sleep <= 1'h1;
		m.start_c();
		m.xfer({own, 1'h0}, 1'h1, got, ack);
		chk_b(ack, 1'h0);
		expect_code(SC_SR_OWN);
		sleep <= 1'h0;
		chk_v(wakes, 1);
		chk_b(scl_oe, 1'h1);
		wr(OFF_CTRL, 8'hC4);
		repeat (2) @(posedge i_clk);
		chk_b(scl_oe, 1'h0);
		m.xfer(d, 1'h1, got, ack);
		expect_code(SC_SR_DATA_ACK);
		wr(OFF_CTRL, 8'hC4);
		m.stop_c();
		final_report();
	end
endmodule
`default_nettype wire
